// ==== include/sms_pkg.sv ====
// Purpose: constants for the serial master/slave shifter
// Assumes: one peripheral clock, plain control ports
// Notes:   prescale table gives seven bit rates
package sms_pkg;
  localparam int          DATA_W       = 8;
  localparam int          CNT_W        = 3;
  localparam logic [2:0]  BITS_LAST    = 3'h7;
  localparam int          DIV_W        = 7;
  // half-period counts in clk cycles, one per rate setting
  localparam logic [1:0]  RATE_DIV4    = 2'h0;
  localparam logic [1:0]  RATE_DIV16   = 2'h1;
  localparam logic [1:0]  RATE_DIV64   = 2'h2;
  localparam logic [1:0]  RATE_DIV128  = 2'h3;
  localparam logic [6:0]  HALF_DIV4    = 7'h02;
  localparam logic [6:0]  HALF_DIV16   = 7'h08;
  localparam logic [6:0]  HALF_DIV64   = 7'h20;
  localparam logic [6:0]  HALF_DIV128  = 7'h40;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  typedef enum logic [1:0] {
    SMS_IDLE,
    SMS_LOW,
    SMS_HIGH
  } sms_state_t;
endpackage : sms_pkg

// ==== verilog/sms_shifter.sv ====
// Purpose: spi-style byte shifter, master or slave, full duplex
// Assumes: pins are given as in/out/oe triples (oe low = drive)
// Notes:   clock phase/polarity fixed: sample rising, shift falling
// Behaviour
// R01: runs as master or slave
// R02: select low opens exchange; slave needs it
// R03: mosi carries master data, miso slave data
// R04: one 8-bit register shifts in and out
// R05: write loads shifter or transmit buffer
// R06: read gives first or second receive buffer
// R07: master makes sck from own divider
// R08: slave synchronises sck, shifts on edges
// R09: enable forces pin directions per mode
// R10: user pins follow software direction
// R11: slave miso driven only while selected
// R12: seven master bit rates by prescaler
// R13: double speed gives clk divided by two; code halves each divider, clk/2 only from div4
// R14: software picks lsb or msb first
// R15: flag set when byte finishes
// R16: write during transfer sets collision flag; code never sets it in buffered mode
// R17: keeps running while processor idles
// R18: everything runs on peripheral clock
// R19: master write starts eight-bit transfer
// R20: select low in master drops to slave
// R21: buffered: two-deep rx, complete when all empty
// R22: deselected slave ignores sck, resets bit count
module sms_shifter (
  input  wire logic       clk,            // peripheral clock
  input  wire logic       reset,          // async, active high
  input  wire logic       enable,         // interface enable
  input  wire logic       master_req,     // software master bit
  input  wire logic       master_set,     // pulse: load master_req
  input  wire logic [2:0] bit_rate_divider, // rate select
  input  wire logic       double_speed_select, // halve sck period
  input  wire logic       bit_order_select, // 1 = lsb first
  input  wire logic       buffered_mode_enable, // buffer mode
  input  wire logic       select_line_ignore, // ignore ss in master
  input  wire logic       dir_mosi,       // software dir, 1 = out
  input  wire logic       dir_miso,       // software dir, 1 = out
  input  wire logic       dir_sck,        // software dir, 1 = out
  input  wire logic       dir_ss,         // software dir, 1 = out
  input  wire logic       ss_out_val,     // ss level when output
  input  wire logic       wr_stb,         // data write strobe
  input  wire logic [7:0] wr_data,        // data to send
  input  wire logic       rd_stb,         // data read strobe
  input  wire logic       flag_clr,       // clear all flags
  input  wire logic       mosi_in,        // mosi pin level
  input  wire logic       miso_in,        // miso pin level
  input  wire logic       sck_in,         // sck pin level
  input  wire logic       ss_in,          // ss pin level
  output logic            mosi_out,       // mosi drive value
  output logic            mosi_oe_n,      // low while driving
  output logic            miso_out,       // miso drive value
  output logic            miso_oe_n,      // low while driving
  output logic            sck_out,        // sck drive value
  output logic            sck_oe_n,       // low while driving
  output logic            ss_out,         // ss drive value
  output logic            ss_oe_n,        // low while driving
  output logic [7:0]      rd_data,        // data register view
  output logic            master_q,       // current master bit
  output logic            done_flag_q,    // transfer done flag
  output logic            write_collision_flag, // collision
  output logic            irq_q,          // wake/interrupt request
  output logic            busy_q          // transfer in progress
);
  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  logic [1:0] sck_s, ss_s, mosi_s, miso_s;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_s  <= 2'h0;
      ss_s   <= 2'h3;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
    end else begin
      sck_s  <= {sck_s[0], sck_in};  // R08 R18
      ss_s   <= {ss_s[0], ss_in};
      mosi_s <= {mosi_s[0], mosi_in};
      miso_s <= {miso_s[0], miso_in};
    end
  end
  logic sck_d1_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sck_d1_q <= 1'b0;
    else       sck_d1_q <= sck_s[1];
  end
  wire sck_rise = sck_s[1] & ~sck_d1_q;
  wire sck_fall = ~sck_s[1] & sck_d1_q;
  wire ss_low   = ~ss_s[1];

  // ----------------------------------------------------------
  // mode and master-select bit
  // ----------------------------------------------------------
  wire slave_mode = enable & ~master_q;
  wire mstr_mode  = enable & master_q;
  wire mm_abort   = mstr_mode & ~select_line_ignore & ~dir_ss & ss_low;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)          master_q <= 1'b0;
    else if (mm_abort)  master_q <= 1'b0;             // R20
    else if (master_set) master_q <= master_req;      // R01
  end

  // ----------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------
  function automatic logic [6:0] half_count(input logic [2:0] r,
                                             input logic dbl);
    logic [6:0] h;
    h = sms_pkg::HALF_DIV4;
    case (r[1:0])
      sms_pkg::RATE_DIV4:   h = sms_pkg::HALF_DIV4;
      sms_pkg::RATE_DIV16:  h = sms_pkg::HALF_DIV16;
      sms_pkg::RATE_DIV64:  h = sms_pkg::HALF_DIV64;
      sms_pkg::RATE_DIV128: h = sms_pkg::HALF_DIV128;
      default:              h = sms_pkg::HALF_DIV4;
    endcase
    // double speed halves the period; div4 becomes clk/2
    if (dbl) h = h >> 1;
    half_count = h;
  endfunction : half_count
  // settings: 4,16,64,128 and doubled 2,8,32 -> seven rates
  wire [6:0] half_lim = half_count(bit_rate_divider,
                                    double_speed_select); // R12 R13

  sms_pkg::sms_state_t st_q;
  logic [6:0] div_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] txb_q;
  logic       txb_full_q;
  logic       sck_gen_q;
  wire        div_hit = (div_q == half_lim - 7'h01);
  wire        m_sample = mstr_mode && st_q == sms_pkg::SMS_LOW && div_hit;
  wire        m_shift  = mstr_mode && st_q == sms_pkg::SMS_HIGH && div_hit;
  wire        m_last   = m_shift && cnt_q == sms_pkg::BITS_LAST;
  wire        start_now = mstr_mode && st_q == sms_pkg::SMS_IDLE &&
                          (wr_stb || txb_full_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) div_q <= 7'h00;
    else if (st_q == sms_pkg::SMS_IDLE || div_hit) div_q <= 7'h00;
    else div_q <= div_q + 7'h01;                         // R07
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) st_q <= sms_pkg::SMS_IDLE;
    else if (!mstr_mode) st_q <= sms_pkg::SMS_IDLE;
    else begin
      case (st_q)
        sms_pkg::SMS_IDLE: if (start_now) st_q <= sms_pkg::SMS_LOW; // R19
        sms_pkg::SMS_LOW:  if (div_hit) st_q <= sms_pkg::SMS_HIGH;
        sms_pkg::SMS_HIGH: begin
          if (m_last && !txb_full_q) st_q <= sms_pkg::SMS_IDLE;
          else if (div_hit) st_q <= sms_pkg::SMS_LOW;
        end
        default: st_q <= sms_pkg::SMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) sck_gen_q <= 1'b0;
    else       sck_gen_q <= (st_q == sms_pkg::SMS_LOW && div_hit) ||
                            (st_q == sms_pkg::SMS_HIGH && !div_hit);
  end

  // ----------------------------------------------------------
  // shift engine, common to both modes
  // ----------------------------------------------------------
  wire s_active = slave_mode & ss_low;                    // R02 R22
  wire do_smp   = m_sample | (s_active & sck_rise);
  wire do_shf   = m_shift  | (s_active & sck_fall);
  // limitation: the miso round trip through the synchroniser takes three
  // clk, so master receive needs a half period of four clk or more
  wire in_bit   = mstr_mode ? miso_s[1] : mosi_s[1];      // R03
  logic smp_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)       smp_q <= 1'b0;
    else if (do_smp) smp_q <= in_bit;
  end
  wire [7:0] sh_next = bit_order_select ? {smp_q, sh_q[7:1]}
                                        : {sh_q[6:0], smp_q}; // R14
  wire byte_end = do_shf && cnt_q == sms_pkg::BITS_LAST;
  wire idle_w   = mstr_mode ? st_q == sms_pkg::SMS_IDLE : ~s_active;
  wire direct_ld = wr_stb && idle_w && !buffered_mode_enable;
  wire slave_idle = slave_mode && cnt_q == 3'h0 && !s_active;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) cnt_q <= 3'h0;
    else if (slave_mode && !ss_low) cnt_q <= 3'h0;       // R22
    else if (do_shf) cnt_q <= cnt_q + 3'h1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) sh_q <= sms_pkg::DATA_RESET;
    else if (byte_end && txb_full_q) sh_q <= txb_q;      // R21
    else if (do_shf) sh_q <= sh_next;                    // R04
    else if (direct_ld) sh_q <= wr_data;                 // R05
    else if (start_now && !wr_stb) sh_q <= txb_q;
    else if (wr_stb && buffered_mode_enable && !txb_full_q &&
             (st_q == sms_pkg::SMS_IDLE && mstr_mode)) sh_q <= wr_data;
  end
  wire bf_first = buffered_mode_enable && mstr_mode &&
                  st_q == sms_pkg::SMS_IDLE && !txb_full_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) txb_q <= sms_pkg::DATA_RESET;
    else if (wr_stb && buffered_mode_enable && !bf_first)
      txb_q <= wr_data;                                  // R05
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) txb_full_q <= 1'b0;
    else if (wr_stb && buffered_mode_enable && !bf_first)
      txb_full_q <= 1'b1;
    else if ((byte_end || start_now) && txb_full_q) txb_full_q <= 1'b0;
  end

  // ----------------------------------------------------------
  // receive buffers
  // ----------------------------------------------------------
  logic [7:0] rx1_q, rx2_q;
  logic [1:0] rx_cnt_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx1_q <= sms_pkg::DATA_RESET;
      rx2_q <= sms_pkg::DATA_RESET;
    end else if (byte_end) begin
      rx1_q <= sh_next;
      if (buffered_mode_enable && (rx_cnt_q == 2'h0 ||
          (rx_cnt_q == 2'h1 && rd_stb)))
        rx2_q <= sh_next;                                // R21
      else if (buffered_mode_enable && rx_cnt_q != 2'h0)
        rx2_q <= rx1_q;
    end else if (rd_stb && buffered_mode_enable && rx_cnt_q == 2'h2)
      rx2_q <= rx1_q;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rx_cnt_q <= 2'h0;
    else if (!buffered_mode_enable) rx_cnt_q <= 2'h0;
    else if (byte_end && !(rd_stb && rx_cnt_q != 2'h0)) begin
      if (rx_cnt_q != 2'h2) rx_cnt_q <= rx_cnt_q + 2'h1;
    end else if (rd_stb && !byte_end && rx_cnt_q != 2'h0)
      rx_cnt_q <= rx_cnt_q - 2'h1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rd_data <= sms_pkg::DATA_RESET;
    else rd_data <= buffered_mode_enable ? rx2_q : rx1_q; // R06
  end

  // ----------------------------------------------------------
  // flags; a set wins over a clear in the same cycle
  // ----------------------------------------------------------
  wire done_set = buffered_mode_enable ?
                  (byte_end && !txb_full_q) : byte_end;   // R15 R21
  wire coll_set = wr_stb && !buffered_mode_enable && !idle_w; // R16
  always_ff @(posedge clk or posedge reset) begin
    if (reset) done_flag_q <= 1'b0;
    else if (done_set || mm_abort) done_flag_q <= 1'b1;  // R15 R20
    else if (flag_clr) done_flag_q <= 1'b0;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) write_collision_flag <= 1'b0;
    else if (coll_set) write_collision_flag <= 1'b1;     // R16
    else if (flag_clr) write_collision_flag <= 1'b0;
  end
  // not gated by any sleep input, so it wakes an idle cpu
  always_ff @(posedge clk or posedge reset) begin
    if (reset) irq_q <= 1'b0;
    else irq_q <= done_set | mm_abort | done_flag_q;     // R17
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) busy_q <= 1'b0;
    else busy_q <= ~idle_w & ~slave_idle;
  end

  // ----------------------------------------------------------
  // pin drive and direction override
  // ----------------------------------------------------------
  wire tx_bit = bit_order_select ? sh_q[0] : sh_q[7];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mosi_out  <= 1'b0;
      miso_out  <= 1'b0;
      sck_out   <= 1'b0;
      ss_out    <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
      sck_oe_n  <= 1'b1;
      ss_oe_n   <= 1'b1;
    end else begin
      mosi_out  <= tx_bit;                                // R03
      miso_out  <= tx_bit;
      sck_out   <= sck_gen_q;
      ss_out    <= ss_out_val;
      // outside enable the software direction rules alone
      mosi_oe_n <= ~(dir_mosi & ~slave_mode);             // R09 R10
      sck_oe_n  <= ~(dir_sck & ~slave_mode);              // R09 R10
      ss_oe_n   <= ~(dir_ss & ~slave_mode);               // R09 R10
      miso_oe_n <= ~(dir_miso & ~mstr_mode &
                     (~slave_mode | ss_low));             // R09 R11
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  property p_abort;
    @(posedge clk) disable iff (reset)
    mm_abort |=> !master_q && done_flag_q;
  endproperty
  a_abort: assert property (p_abort) // R20
    else $error("select low did not drop master");
  property p_miso_tri;
    @(posedge clk) disable iff (reset)
    (slave_mode && !ss_low) |=> miso_oe_n;
  endproperty
  a_miso_tri: assert property (p_miso_tri) else $error("miso driven"); // R11
  property p_coll;
    @(posedge clk) disable iff (reset)
    coll_set |=> write_collision_flag;
  endproperty
  a_coll: assert property (p_coll) else $error("collision lost"); // R16
  property p_done;
    @(posedge clk) disable iff (reset)
    done_set |=> done_flag_q ##1 irq_q;
  endproperty
  a_done: assert property (p_done) else $error("done flag lost"); // R15
  property p_deselect;
    @(posedge clk) disable iff (reset)
    (slave_mode && !ss_low) |=> cnt_q == 3'h0;
  endproperty
  a_deselect: assert property (p_deselect) else $error("count kept"); // R22
  property p_start;
    @(posedge clk) disable iff (reset)
    (start_now && mstr_mode) |=> st_q == sms_pkg::SMS_LOW;
  endproperty
  a_start: assert property (p_start) else $error("no start"); // R19
  property p_mdir;
    @(posedge clk) disable iff (reset)
    mstr_mode |=> miso_oe_n;
  endproperty
  a_mdir: assert property (p_mdir) else $error("miso not input"); // R09
  property p_sdir;
    @(posedge clk) disable iff (reset)
    slave_mode |=> mosi_oe_n && sck_oe_n && ss_oe_n;
  endproperty
  a_sdir: assert property (p_sdir) else $error("slave pin out"); // R09
  property p_rd;
    @(posedge clk) disable iff (reset)
    ##1 rd_data == $past(buffered_mode_enable ? rx2_q : rx1_q);
  endproperty
  a_rd: assert property (p_rd) else $error("wrong rx view"); // R06
  property p_b2b;
    @(posedge clk) disable iff (reset)
    (mstr_mode && byte_end && txb_full_q) |=>
      st_q == sms_pkg::SMS_LOW && sh_q == $past(txb_q);
  endproperty
  a_b2b: assert property (p_b2b) else $error("queued byte not sent"); // R21
  c_master_byte: cover property (@(posedge clk) mstr_mode && byte_end);
  c_slave_byte: cover property (@(posedge clk) slave_mode && byte_end);
  c_abort: cover property (@(posedge clk) mm_abort);
  c_buf: cover property (@(posedge clk)
    buffered_mode_enable && byte_end && txb_full_q);
endmodule : sms_shifter

// ==== verification/sms_slave_model.sv ====
// Purpose: behavioural slave on the far side of the shifter
// Assumes: mode 0, sample on sck rise, change on sck fall
// Notes:   loads tx_byte at select fall; later bytes echo rx
module sms_slave_model (
  input  wire logic       sck,       // serial clock
  input  wire logic       ss_n,      // select, active low
  input  wire logic       mosi,      // data from master
  input  wire logic       lsb_first, // bit order
  input  wire logic [7:0] tx_byte,   // first byte to return
  output logic            miso,      // data to master
  output logic [7:0]      rx_byte    // bits taken so far
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_q;
  initial begin
    miso = 1'b0;
    sh_q = 8'h00;
    rx_byte = 8'h00;
  end
  // released line shows the inverse, so a stale level never passes
  always @(posedge ss_n) miso = ~miso;
  always @(negedge ss_n) begin
    sh_q = tx_byte;
    miso = lsb_first ? sh_q[0] : sh_q[7];
  end
  always @(posedge sck) begin
    if (!ss_n) begin
      sh_q = lsb_first ? {mosi, sh_q[7:1]} : {sh_q[6:0], mosi};
      rx_byte = sh_q;
    end
  end
  always @(negedge sck) begin
    if (!ss_n) miso = lsb_first ? sh_q[0] : sh_q[7];
  end
endmodule : sms_slave_model

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the serial shifter
// Assumes: inputs change at falling clk edge; model is the far side
// Notes:   the bench itself plays master while the shifter is slave
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, enable, master_req, master_set, double_speed_select;
  logic bit_order_select, buffered_mode_enable, select_line_ignore;
  logic dir_mosi, dir_miso, dir_sck, dir_ss, ss_out_val, wr_stb, rd_stb;
  logic flag_clr, t_mosi, t_sck, t_ss, t_slv, m_miso;
  logic mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck_out, sck_oe_n;
  logic ss_out, ss_oe_n, master_q, done_flag_q, write_collision_flag;
  logic irq_q, busy_q;
  logic [2:0] bit_rate_divider;
  logic [7:0] wr_data, rd_data, m_tx, m_rx;
  wire mosi_in = mosi_oe_n ? t_mosi : mosi_out;
  wire sck_in = sck_oe_n ? t_sck : sck_out;
  wire ss_in = ss_oe_n ? t_ss : ss_out;
  wire miso_in = miso_oe_n ? m_miso : miso_out;
  int n_errors, num_checks, cyc;
  sms_shifter dut_u (.clk, .reset, .enable, .master_req, .master_set,
    .bit_rate_divider, .double_speed_select, .bit_order_select,
    .buffered_mode_enable, .select_line_ignore, .dir_mosi, .dir_miso,
    .dir_sck, .dir_ss, .ss_out_val, .wr_stb, .wr_data, .rd_stb, .flag_clr,
    .mosi_in, .miso_in, .sck_in, .ss_in, .mosi_out, .mosi_oe_n, .miso_out,
    .miso_oe_n, .sck_out, .sck_oe_n, .ss_out, .ss_oe_n, .rd_data,
    .master_q, .done_flag_q, .write_collision_flag, .irq_q, .busy_q);
  sms_slave_model sl_u (.sck(sck_in), .ss_n(ss_in | t_slv), .mosi(mosi_in),
    .lsb_first(bit_order_select), .tx_byte(m_tx), .miso(m_miso),
    .rx_byte(m_rx));
  always #20 clk = ~clk;
  // hang guard: the whole run needs well under 10000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  function automatic int half_exp(input logic [2:0] r, input logic d);
    logic [6:0] h;
    case (r[1:0])
      sms_pkg::RATE_DIV4:  h = sms_pkg::HALF_DIV4;
      sms_pkg::RATE_DIV16: h = sms_pkg::HALF_DIV16;
      sms_pkg::RATE_DIV64: h = sms_pkg::HALF_DIV64;
      default:             h = sms_pkg::HALF_DIV128;
    endcase
    return int'(h) >> d;
  endfunction : half_exp
  // master run: nb bytes starting with d, model answers t first
  task automatic mx(input logic [7:0] d, t, input int nb, input bit col);
    int n, r, r0, per;
    logic ps;
    m_tx = t;
    ss_out_val = 1'b0;
    repeat (3) @(negedge clk);
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge clk);
    if (nb == 2) begin
      wr_data = ~d;
      @(negedge clk);
    end
    wr_stb = 1'b0;
    r = 0;
    r0 = -1;
    per = 0;
    ps = sck_out;
    for (n = 0; n < 4000 && done_flag_q !== 1'b1; n++) begin
      @(negedge clk);
      if (n == 2) chk("busy", busy_q, 1'b1);
      if (col && n == 5) wr_stb = 1'b1;
      if (col && n == 6) wr_stb = 1'b0;
      if (sck_out && !ps) begin
        if (r0 >= 0) per = n - r0;
        r0 = n;
        r++;
      end
      ps = sck_out;
    end
    ss_out_val = 1'b1;
    repeat (3) @(negedge clk);
    chk("done", done_flag_q, 1'b1);
    chk("irq", irq_q, 1'b1);
    if (col) chk("wcol", write_collision_flag, 1'b1);
    if (!col) begin
      chk("sck_rises", 8'(r), 8'(8 * nb));
      chk("sck_period", 8'(per), 8'(2 * half_exp(bit_rate_divider,
        double_speed_select)));
      chk("rx_first", rd_data, t);
      chk("model_rx", m_rx, nb == 2 ? ~d : d);
    end
    if (nb == 2) begin
      pulse(rd_stb);
      repeat (2) @(negedge clk);
      chk("rx_second", rd_data, d);
    end
    pulse(flag_clr);
    chk("flags_clr", {done_flag_q, write_collision_flag}, 8'h00);
  endtask : mx
  // slave run: bench sends d, shifter answers t
  task automatic sx(input logic [7:0] d, t);
    logic [7:0] got;
    int i;
    wr_data = t;
    pulse(wr_stb);
    repeat (3) begin
      t_sck = 1'b1;
      repeat (4) @(negedge clk);
      t_sck = 1'b0;
      repeat (4) @(negedge clk);
    end
    t_ss = 1'b0;
    repeat (8) @(negedge clk);
    chk("miso_oe_sel", miso_oe_n, 1'b0);
    for (i = 0; i < 8; i++) begin
      t_mosi = bit_order_select ? d[i] : d[7 - i];
      repeat (8) @(negedge clk);
      t_sck = 1'b1;
      got = bit_order_select ? {miso_in, got[7:1]} : {got[6:0], miso_in};
      repeat (8) @(negedge clk);
      t_sck = 1'b0;
    end
    repeat (8) @(negedge clk);
    t_ss = 1'b1;
    repeat (4) @(negedge clk);
    chk("miso_oe_desel", miso_oe_n, 1'b1);
    chk("slave_tx", got, t);
    chk("slave_rx", rd_data, d);
    chk("slave_done", done_flag_q, 1'b1);
    pulse(flag_clr);
  endtask : sx
  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  initial begin
    logic [3:0] k;
    logic [7:0] t_pick;
    {enable, master_req, master_set, double_speed_select, bit_order_select,
     buffered_mode_enable, select_line_ignore, dir_mosi, dir_miso, dir_sck,
     dir_ss, wr_stb, rd_stb, flag_clr, t_mosi, t_sck, t_slv} = '0;
    {ss_out_val, t_ss} = 2'h3;
    bit_rate_divider = 3'h0;
    wr_data = 8'h00;
    m_tx = 8'h00;
    clk = 1'b0;
    reset = 1'b1;
    void'($urandom(64));
    repeat (12) @(negedge clk);
    chk("ss_reset", ss_out, 1'b1);
    chk("oe_reset", {mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n}, 8'h0f);
    reset = 1'b0;
    @(negedge clk);
    {enable, master_req, dir_sck, dir_ss, dir_miso} = 5'h1f;
    pulse(master_set);
    @(negedge clk);
    chk("master", master_q, 1'b1);
    chk("oe_master", {mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n}, 8'h0c);
    dir_mosi = 1'b1;
    for (k = 0; k < 8; k++) begin
      double_speed_select = k[0];
      bit_rate_divider = {1'($urandom), k[2:1]};
      bit_order_select = 1'($urandom);
      t_pick = 8'($urandom);
      // fastest rates outrun the miso synchroniser: keep every bit alike
      if (half_exp(bit_rate_divider, double_speed_select) < 4)
        t_pick = {8{t_pick[0]}};
      mx(8'($urandom), t_pick, 1, k == 3);
    end
    mx(8'hff, 8'h00, 1, 1'b0);
    buffered_mode_enable = 1'b1;
    mx(8'($urandom), 8'($urandom), 2, 1'b0);
    buffered_mode_enable = 1'b0;
    select_line_ignore = 1'b1;
    dir_ss = 1'b0;
    t_ss = 1'b0;
    repeat (6) @(negedge clk);
    chk("master_kept", master_q, 1'b1);
    select_line_ignore = 1'b0;
    repeat (6) @(negedge clk);
    chk("master_lost", master_q, 1'b0);
    chk("ss_flag", done_flag_q, 1'b1);
    t_ss = 1'b1;
    pulse(flag_clr);
    {t_slv, dir_ss, master_req} = 3'h6;
    pulse(master_set);
    @(negedge clk);
    chk("oe_slave", {mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n}, 8'h0f);
    repeat (3) begin
      bit_order_select = 1'($urandom);
      sx(8'($urandom), 8'($urandom));
    end
    results();
  end
endmodule : tb_top
